// file: verilog/dshp_pkg.sv
// Purpose: shared constants and types for the servo position and motion block
// Assumes: one clock, positions and velocities in encoder counts
// Notes:   velocity is counts per 2^VEL_FRAC_BITS clock cycles
package dshp_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int POS_W          = 32;
    localparam int VEL_W          = 24;
    localparam int VEL_FRAC_BITS  = 16;
    localparam logic [31:0] POS_RST = 32'h0000_0000;
    localparam logic [23:0] VEL_RST = 24'h00_0000;

    // rotary wrap default: counts for one full turn of 360 degrees
    localparam logic [31:0] REV_COUNTS_DEF = 32'h0000_0E10;

    // motion sequencer states
    typedef enum logic [5:0] {
        DSHP_IDLE   = 6'h01,
        DSHP_ACCEL  = 6'h02,
        DSHP_CRUISE = 6'h04,
        DSHP_DECEL  = 6'h08,
        DSHP_SEEK   = 6'h10,
        DSHP_OFFSET = 6'h20
    } dshp_state_type;

endpackage : dshp_pkg

// file: verilog/dshp_cnt_if.sv
// Purpose: carrier between the sequencer and the position counter
// Assumes: single clock domain
// Notes:   step and dir come from the encoder inputs, clear from the sequencer
`timescale 1ns/1ps
interface dshp_cnt_if;
    logic                          step;
    logic                          dir_pos;
    logic                          clear;
    logic [dshp_pkg::POS_W-1:0]    count;

    modport master (output step, output dir_pos, output clear, input count);
    modport counter (input step, input dir_pos, input clear, output count);
endinterface : dshp_cnt_if

// file: verilog/dshp_pos_counter.sv
// Purpose: net encoder count for one motor
// Assumes: reset already synchronised by the top
// Notes:   clear has priority over a step in the same cycle
`timescale 1ns/1ps
module dshp_pos_counter (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // counter carrier
    dshp_cnt_if.counter      cif
);
    import dshp_pkg::*;

    logic [POS_W-1:0] count_r;
    logic [POS_W-1:0] count_nxt;

    // up or down by one per encoder step
    assign count_nxt = cif.clear ? POS_RST :
                       !cif.step ? count_r :
                       cif.dir_pos ? count_r + 1'b1 : count_r - 1'b1;
    assign cif.count = count_r;

    // power-up value is zero, no datum known yet
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) count_r <= POS_RST;
        else        count_r <= count_nxt;
    end
endmodule : dshp_pos_counter

// file: verilog/dshp_servo_top.sv
// Purpose: position keeping and trapezoidal motion sequencing, one axis
// Assumes: encoder step/dir pulses and switches synchronous to mclk
// Notes:   commands are one-cycle pulses; distances in encoder counts
//
// Summary of operation
// - every position counter reads zero after power-up reset.
// - counter tracks net encoder counts, up or down by direction.
// - current counter value is presented on request as the position report.
// - homing drives negative to the limit, then positive by zero offset.
// - counter cleared to zero on arrival at home.
// - active negative limit stops negative-direction motion on a linear stage.
// - negative limit is the datum the homing search looks for.
// - moves ramp at programmed acceleration, capped at programmed maximum velocity.
// - near target, decelerate at the same rate for a controlled arrival.
// - positive move goes from smaller to larger position, negative reverse.
// - rotary stage: switch only a datum, motion passes through it.
// - immediate stop halts the move at once, no ramp.
// - profiled stop decelerates the move to rest along the profile.
// - rotary position report wraps into 0 to 360 degrees from home.
`timescale 1ns/1ps
module dshp_servo_top #(
    parameter int POS_W = dshp_pkg::POS_W,
    parameter int VEL_W = dshp_pkg::VEL_W
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         arst_n,
    // move and stop commands
    input  wire logic                         move_cmd,
    input  wire logic [dshp_pkg::POS_W-1:0]   move_dist,
    input  wire logic                         move_neg,
    input  wire logic                         datum_seek_cmd,
    input  wire logic                         halt_now_cmd,
    input  wire logic                         ramped_halt_cmd,
    // profile settings
    input  wire logic [dshp_pkg::VEL_W-1:0]   accel,
    input  wire logic [dshp_pkg::VEL_W-1:0]   max_vel,
    input  wire logic [dshp_pkg::VEL_W-1:0]   home_vel,
    input  wire logic [dshp_pkg::POS_W-1:0]   zero_offset,
    input  wire logic [dshp_pkg::POS_W-1:0]   rev_counts,
    // stage configuration and switches
    input  wire logic                         rotary_stage,
    input  wire logic                         pos_lim_fitted,
    input  wire logic                         neg_lim,
    input  wire logic                         pos_lim,
    // encoder feedback
    input  wire logic                         enc_step,
    input  wire logic                         enc_dir_pos,
    // position report
    input  wire logic                         pos_req,
    output logic                              pos_valid,
    output logic [dshp_pkg::POS_W-1:0]        pos_report,
    // motor demand and status
    output logic [dshp_pkg::VEL_W-1:0]        vel_cmd,
    output logic                              dir_pos_out,
    output logic                              busy,
    output logic                              homed
);
    import dshp_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    // assert at once, release after two edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------
    dshp_cnt_if cif ();
    dshp_pos_counter u_cnt (
        .mclk  (mclk),
        .rst_n (rst_n_r),
        .cif   (cif)
    );

    dshp_state_type   state_r;
    dshp_state_type   state_nxt;
    logic [VEL_W-1:0] vel_r;
    logic [VEL_W-1:0] vel_nxt;
    logic [POS_W-1:0] remain_r;
    logic [POS_W-1:0] remain_nxt;
    logic [POS_W-1:0] brake_r;
    logic [POS_W-1:0] brake_nxt;
    logic [VEL_FRAC_BITS-1:0] frac_r;
    logic             dir_r;
    logic             dir_nxt;
    logic             homed_r;
    logic             homed_nxt;

    assign cif.step    = enc_step;
    assign cif.dir_pos = enc_dir_pos;
    assign cif.clear   = (state_r == DSHP_OFFSET) && (remain_r == '0);

    // ------------------------------------------------------------
    // decode of stop conditions
    // ------------------------------------------------------------
    wire moving    = (state_r != DSHP_IDLE);
    // rotary stages ignore the switch as a stop and pass through it
    wire neg_block = neg_lim && !rotary_stage && !dir_r && moving;
    wire pos_block = pos_lim && pos_lim_fitted && !rotary_stage
                     && dir_r && moving;
    wire hard_stop = halt_now_cmd || neg_block || pos_block;
    wire seek_hit  = (state_r == DSHP_SEEK) && neg_lim;
    // one bit wider so a large step cannot wrap past the ceiling
    wire [VEL_W:0]   vel_sum  = {1'b0, vel_r} + {1'b0, accel};
    wire [VEL_W-1:0] vel_up   = (vel_sum > {1'b0, max_vel}) ? max_vel
                                                            : vel_sum[VEL_W-1:0];
    // floor at one ramp step so the final creep still ends in bounded time
    wire [VEL_W-1:0] vel_down = (vel_r > accel) ? VEL_W'(vel_r - accel) : accel;
    // braking distance mirrors the ramp-up distance; brake_r holds sub-count
    // units, so the estimate only holds up to 2^16 counts of ramp travel
    wire [POS_W-1:0] brake_add = POS_W'(vel_up);
    wire [POS_W-1:0] brake_cnt = POS_W'(brake_r >> VEL_FRAC_BITS) + 1'b1;
    wire [VEL_FRAC_BITS:0] frac_sum = {1'b0, frac_r} + {1'b0, vel_r[VEL_FRAC_BITS-1:0]};
    wire [POS_W-1:0] adv = POS_W'(vel_r >> VEL_FRAC_BITS) + POS_W'(frac_sum[VEL_FRAC_BITS]);
    wire [POS_W-1:0] remain_adv = (remain_r > adv) ? remain_r - adv : '0;
    wire near_end  = (remain_r <= brake_cnt);

    // ------------------------------------------------------------
    // motion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        vel_nxt    = vel_r;
        remain_nxt = remain_r;
        brake_nxt  = brake_r;
        dir_nxt    = dir_r;
        homed_nxt  = homed_r;
        unique case (state_r)
            DSHP_IDLE: begin
                vel_nxt   = VEL_RST;
                brake_nxt = '0;
                if (datum_seek_cmd) begin
                    state_nxt = DSHP_SEEK;
                    dir_nxt   = 1'b0;
                    homed_nxt = 1'b0;
                    vel_nxt   = home_vel;
                end else if (move_cmd && move_dist != '0) begin
                    state_nxt  = DSHP_ACCEL;
                    dir_nxt    = !move_neg;
                    remain_nxt = move_dist;
                end
            end
            DSHP_ACCEL, DSHP_CRUISE: begin
                remain_nxt = remain_adv;
                if (ramped_halt_cmd || near_end) begin
                    state_nxt = DSHP_DECEL;
                    if (ramped_halt_cmd) remain_nxt = brake_cnt;
                end else if (state_r == DSHP_ACCEL) begin
                    vel_nxt   = vel_up;
                    brake_nxt = brake_r + brake_add;
                    if (vel_up == max_vel) state_nxt = DSHP_CRUISE;
                end
            end
            DSHP_DECEL: begin
                remain_nxt = remain_adv;
                vel_nxt    = vel_down;
                if (remain_adv == '0) begin
                    state_nxt = DSHP_IDLE;
                    vel_nxt   = VEL_RST;                           // no creep past target
                end
            end
            DSHP_SEEK: begin
                if (seek_hit) begin
                    state_nxt  = DSHP_OFFSET;
                    dir_nxt    = 1'b1;
                    remain_nxt = zero_offset;
                end
            end
            DSHP_OFFSET: begin
                remain_nxt = remain_adv;
                if (remain_r == '0) begin
                    state_nxt = DSHP_IDLE;
                    vel_nxt   = VEL_RST;                           // stand still at datum
                    homed_nxt = 1'b1;
                end
            end
        endcase
        // immediate halt; the seek itself expects the negative limit
        if (hard_stop && !(state_r == DSHP_SEEK && !halt_now_cmd)
            && !(state_r == DSHP_OFFSET && !halt_now_cmd)) begin
            state_nxt = DSHP_IDLE;
            vel_nxt   = VEL_RST;
        end
    end

    // sequencer registers
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r  <= DSHP_IDLE;
            vel_r    <= VEL_RST;
            remain_r <= POS_RST;
            brake_r  <= POS_RST;
            dir_r    <= 1'b1;
            homed_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            vel_r    <= vel_nxt;
            remain_r <= remain_nxt;
            brake_r  <= brake_nxt;
            dir_r    <= dir_nxt;
            homed_r  <= homed_nxt;
        end
    end

    // fractional accumulator for sub-count velocity
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) frac_r <= '0;
        else          frac_r <= moving ? frac_sum[VEL_FRAC_BITS-1:0] : '0;
    end

    // ------------------------------------------------------------
    // position report
    // ------------------------------------------------------------
    // negative counts fold up by one turn; assumes position within one turn
    wire [POS_W-1:0] cnt_now  = cif.count;
    wire [POS_W-1:0] wrap_neg = cnt_now + rev_counts;
    wire [POS_W-1:0] wrap_pos = (cnt_now >= rev_counts) ? cnt_now - rev_counts : cnt_now;
    wire [POS_W-1:0] rot_pos  = cnt_now[POS_W-1] ? wrap_neg : wrap_pos;
    logic [POS_W-1:0] pos_report_r;
    logic             pos_valid_r;

    // report registered one cycle after the request
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pos_report_r <= POS_RST;
            pos_valid_r  <= 1'b0;
        end else begin
            pos_valid_r  <= pos_req;
            if (pos_req) pos_report_r <= rotary_stage ? rot_pos : cnt_now;
        end
    end

    assign pos_valid   = pos_valid_r;
    assign pos_report  = pos_report_r;
    assign vel_cmd     = vel_r;
    assign dir_pos_out = dir_r;
    assign busy        = moving;
    assign homed       = homed_r;

endmodule : dshp_servo_top

// file: verification/dshp_servo_chk.sv
// Purpose: port-level property checks for the servo motion block
// Assumes: single clock domain, active-low reset
// Notes:   bound from tb_top onto the top module ports
`timescale 1ns/1ps
module dshp_servo_chk (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       arst_n,
    // commands and settings
    input wire logic                       move_cmd,
    input wire logic [dshp_pkg::POS_W-1:0] move_dist,
    input wire logic                       datum_seek_cmd,
    input wire logic                       halt_now_cmd,
    input wire logic                       ramped_halt_cmd,
    input wire logic [dshp_pkg::VEL_W-1:0] accel,
    input wire logic [dshp_pkg::VEL_W-1:0] max_vel,
    input wire logic                       rotary_stage,
    input wire logic                       pos_lim_fitted,
    input wire logic                       neg_lim,
    input wire logic                       pos_lim,
    input wire logic                       pos_req,
    // status
    input wire logic                       pos_valid,
    input wire logic [dshp_pkg::VEL_W-1:0] vel_cmd,
    input wire logic                       dir_pos_out,
    input wire logic                       busy,
    input wire logic                       homed
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // start, ramp limits and ceiling of the velocity demand
    a_move_start: assert property (move_cmd && !busy && move_dist != 0 && !datum_seek_cmd
        && !halt_now_cmd |-> ##[1:2] busy) else $error("move not started");
    a_vel_cap: assert property (busy && homed |-> vel_cmd <= max_vel)
        else $error("velocity above max");
    a_accel_step: assert property (busy && $past(busy) && vel_cmd > $past(vel_cmd)
        |-> vel_cmd - $past(vel_cmd) <= accel) else $error("ramp up too steep");
    a_decel_step: assert property (busy && $past(busy) && vel_cmd < $past(vel_cmd)
        |-> $past(vel_cmd) - vel_cmd <= accel) else $error("ramp down too steep");
    // stops: abrupt halt must land next cycle, profiled one must not
    a_halt_now: assert property (halt_now_cmd |=> !busy && vel_cmd == 0)
        else $error("halt not immediate");
    a_ramp_soft: assert property (ramped_halt_cmd && busy && vel_cmd > 2 * accel
        && !halt_now_cmd |=> busy && vel_cmd != 0) else $error("ramped halt abrupt");
    // switches
    a_neg_stop: assert property (busy && !dir_pos_out && neg_lim && !rotary_stage
        |=> !busy || dir_pos_out) else $error("negative limit ignored");
    a_pos_stop: assert property (busy && dir_pos_out && pos_lim && pos_lim_fitted
        && !rotary_stage |=> !busy) else $error("positive limit ignored");
    a_rot_pass: assert property (rotary_stage && homed && busy && neg_lim
        && vel_cmd > accel |=> busy) else $error("rotary stopped at switch");
    a_seek_start: assert property (datum_seek_cmd && !busy && !halt_now_cmd
        |=> busy && !dir_pos_out && !homed) else $error("seek not negative");
    a_rpt_ready: assert property (pos_req |=> pos_valid)
        else $error("report late");
    c_homed: cover property ($rose(homed));
    c_cruise: cover property (busy && vel_cmd == max_vel);
    c_halt: cover property (halt_now_cmd && busy);
endmodule : dshp_servo_chk

// file: verification/dshp_stage_model.sv
// Purpose: behavioural stage with encoder and limit switches
// Assumes: demand in counts per 65536 cycles, below one count per cycle
// Notes:   switches are positions of the modelled carriage
`timescale 1ns/1ps
module dshp_stage_model #(
    parameter int START = 60,
    parameter int PLIM  = 400
) (
    input  wire logic        mclk,
    input  wire logic [23:0] vel_cmd,
    input  wire logic        dir_pos_out,
    input  wire logic        rotary_stage,
    output logic             enc_step,
    output logic             enc_dir_pos,
    output logic             neg_lim,
    output logic             pos_lim
);
    logic [16:0] frac_r = 17'h0_0000;
    int          pos_r  = START;
    initial {enc_step, enc_dir_pos, neg_lim, pos_lim} = 4'h0;
    // integrate demand; a carry out is one encoder count
    always @(negedge mclk) begin
        frac_r = {1'b0, frac_r[15:0]} + {1'b0, vel_cmd[15:0]};
        enc_step = frac_r[16];
        enc_dir_pos = dir_pos_out;
        if (frac_r[16]) pos_r = dir_pos_out ? pos_r + 1 : pos_r - 1;
        // rotary switch only marks the datum, carriage passes it
        neg_lim = rotary_stage ? (pos_r == 0) : (pos_r <= 0);
        pos_lim = pos_r >= PLIM;
    end
endmodule : dshp_stage_model

// file: verification/tb_top.sv
// Purpose: self-checking bench for the servo motion block
// Assumes: stage model supplies encoder and switches
// Notes:   positions allow a count or two of slip at stops
`timescale 1ns/1ps
module tb_top;
    import dshp_pkg::*;
    logic             mclk = 1'b0, arst_n = 1'b0, move_cmd = 1'b0, move_neg = 1'b0;
    logic             datum_seek_cmd = 1'b0, halt_now_cmd = 1'b0, ramped_halt_cmd = 1'b0;
    logic             pos_req = 1'b0, rotary_stage = 1'b0, pos_lim_fitted = 1'b0;
    logic [POS_W-1:0] move_dist = '0, zero_offset = 32'h0000_000A, rev_counts = REV_COUNTS_DEF;
    logic [VEL_W-1:0] accel = 24'h00_0400, max_vel = 24'h00_8000, home_vel = 24'h00_8000;
    logic             neg_lim, pos_lim, enc_step, enc_dir_pos, pos_valid, dir_pos_out;
    logic             busy, homed;
    logic [POS_W-1:0] pos_report, r, r0;
    logic [VEL_W-1:0] vel_cmd;
    int               n_errors = 0, num_checks = 0, cyc = 0;
    dshp_servo_top uut (.*);
    dshp_stage_model #(.START(60), .PLIM(400)) stage (.*);
    always #20 mclk = ~mclk;
    task end_of_test;
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // hang guard, runs are a few thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    // tolerance window, unknowns always mismatch
    task chk(string nm, logic [31:0] seen, logic [31:0] exp, logic [31:0] tol);
        num_checks++;
        if (((seen - exp + tol) <= 2 * tol) !== 1'b1) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask : pulse
    task wait_idle;
        @(negedge mclk);
        while (busy === 1'b1) @(negedge mclk);
    endtask : wait_idle
    task rd;
        pulse(pos_req);
        chk("report valid", pos_valid, 1, 0);
        @(negedge mclk);
        r = pos_report;
    endtask : rd
    // distances already in encoder counts
    task go(logic [31:0] d, logic neg);
        move_dist = d;
        move_neg = neg;
        pulse(move_cmd);
        wait_idle();
    endtask : go
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_power_up;
        rd();
        chk("pos after reset", r, 0, 0);
        chk("dir idle", dir_pos_out, 1, 0);
    endtask : t_power_up
    task t_home;
        pulse(datum_seek_cmd);
        wait_idle();
        chk("homed", homed, 1, 0);
        rd();
        chk("pos at home", r, 0, 1);
    endtask : t_home
    task t_moves;
        go(200, 1'b0);
        rd();
        chk("pos after up", r, 200, 2);
        go(100, 1'b1);
        rd();
        chk("pos after down", r, 100, 2);
        go(6, 1'b0);
        rd();
        chk("pos after short", r, 106, 2);
    endtask : t_moves
    task t_stops;
        move_dist = 32'h0000_03E8;
        move_neg = 1'b0;
        pulse(move_cmd);
        repeat (50) @(negedge mclk);
        pulse(halt_now_cmd);
        chk("busy after halt", busy, 0, 0);
        chk("vel after halt", vel_cmd, 0, 0);
        rd();
        r0 = r;
        pulse(move_cmd);
        repeat (60) @(negedge mclk);
        pulse(ramped_halt_cmd);
        chk("busy in ramp", busy, 1, 0);
        wait_idle();
        rd();
        chk("ramp length", r - r0, 32, 12);
    endtask : t_stops
    task t_limits;
        pos_lim_fitted = 1'b1;
        go(32'h0000_07D0, 1'b0);
        chk("pos switch", pos_lim, 1, 0);
        rd();
        chk("pos at plim", r, 390, 2);
        go(32'h0000_0BB8, 1'b1);
        chk("neg switch", neg_lim, 1, 0);
        rd();
        chk("pos at nlim", r, 32'hFFFF_FFF6, 2);
    endtask : t_limits
    task t_rotary;
        rotary_stage = 1'b1;
        rev_counts = 32'h0000_0100;
        go(32'h0000_0032, 1'b1);
        rd();
        chk("rotary wrap", r, 32'h0000_00CE, 2);
    endtask : t_rotary
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_power_up();
        t_home();
        t_moves();
        t_stops();
        t_limits();
        t_home();
        t_rotary();
        end_of_test();
    end
endmodule : tb_top
bind dshp_servo_top dshp_servo_chk chk (.*);
